// ==== core/rtsc_pkg.sv ====
// Constants for the reference and temperature sensor control block.
// Assumes an 8-bit special-function register bus with address and page.
package rtsc_pkg;

    // ************************************************************
    // Register location
    // ************************************************************
    localparam logic [7:0] RTSC_REF_CTL_ADDR = 8'hd1;   // Register address
    localparam logic [7:0] RTSC_REF_CTL_PAGE = 8'h00;   // Register page
    localparam logic [7:0] RTSC_REF_CTL_RESET = 8'h00;  // Whole register reset

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int RTSC_BIT_BUF_EN = 0;     // reference_buffer_enable
    localparam int RTSC_BIT_BIAS_EN = 1;    // bias_generator_enable
    localparam int RTSC_BIT_TEMP_EN = 2;    // temp_sensor_enable
    localparam int RTSC_BIT_SRC_SEL = 3;    // reference_source_select
    localparam int RTSC_BIT_LEVEL = 4;      // reference_level_select
    localparam int RTSC_BIT_ZTC = 5;        // zero_tc_bias_force
    localparam int RTSC_CTL_W = 4;          // Writable low fields

    localparam logic [RTSC_CTL_W-1:0] RTSC_CTL_RESET = 4'h0;  // Writable fields reset

    // ************************************************************
    // Other encodings
    // ************************************************************
    localparam logic [5:0] RTSC_CH_TEMP = 6'h30;    // Channel code of the sensor
    localparam logic [1:0] RTSC_UNUSED_RD = 2'h0;   // Bits 7:6 read value
    localparam logic RTSC_SRC_PIN = 1'b0;           // Source select: reference pin
    localparam logic RTSC_SRC_SUPPLY = 1'b1;        // Source select: supply

endpackage : rtsc_pkg

// ==== core/rtsc_reg_if.sv ====
// Carrier between the top module and the register storage.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface rtsc_reg_if;
    import rtsc_pkg::*;

    logic wr_en;                        // Write strobe, one cycle
    logic [7:0] wr_data;                // Write data from the bus
    logic [RTSC_CTL_W-1:0] ctl;         // Stored writable fields

    // Storage side
    modport store
    (
        input wr_en,
        input wr_data,
        output ctl
    );

    // Control side
    modport user
    (
        output wr_en,
        output wr_data,
        input ctl
    );

endinterface : rtsc_reg_if

// ==== core/rtsc_field_reg.sv ====
// Storage of the writable fields of the reference control register.
// Assumes the write strobe is already decoded for address and page.
`timescale 1ns/1ps
module rtsc_field_reg
    import rtsc_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Register carrier
    rtsc_reg_if.store regs
);

    // ************************************************************
    // Field storage
    // ************************************************************
    logic [RTSC_CTL_W-1:0] ctl_reg;     // Held fields
    logic [RTSC_CTL_W-1:0] ctl_next;    // Next value

    // Only the low writable bits are taken; upper bits are dropped here
    assign ctl_next = regs.wr_en ? regs.wr_data[RTSC_CTL_W-1:0] : ctl_reg;

    // Update on the write edge itself
    always_ff @(posedge CLK)
    begin
        if (RESET)
            ctl_reg <= RTSC_CTL_RESET;
        else
            ctl_reg <= ctl_next;
    end

    assign regs.ctl = ctl_reg;

endmodule : rtsc_field_reg

// ==== core/rtsc_top.sv ====
// Reference multiplexer, reference buffer, bias and sensor enable control.
// Assumes a synchronous register bus and level status from neighbours.
//
// Behaviour
// - Source select 0 picks pin, 1 supply
// - Sensor powered only while enable bit set
// - Disabled sensor output high impedance, readings invalid
// - Bias on when ADC, sensor or oscillator on
// - Bias enable 1 forces bias on
// - Buffer enable drives reference onto pin
// - Level field reports 1.5 V or 2.20 V
// - Bits 7 and 6 read zero, ignore writes
// - Supply reference with ADC blocks open-drain pin
// - Register at 0xD1 page 0x00, resets zero
`timescale 1ns/1ps
module rtsc_top
    import rtsc_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Special-function register bus
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_PAGE,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    // Status of neighbouring blocks
    input wire logic ADC_ENABLE,
    input wire logic OSC_ENABLE,
    input wire logic [5:0] ADC_CHANNEL_SELECT,
    input wire logic REF_LEVEL_SELECT,
    input wire logic ZERO_TC_BIAS_FORCE,
    // Analog controls
    output logic REF_SOURCE_SUPPLY,
    output logic TEMP_SENSOR_POWER,
    output logic TEMP_SENSOR_OUT_EN,
    output logic TEMP_SAMPLE_VALID,
    output logic BIAS_GEN_ON,
    output logic ZERO_TC_BIAS_ON,
    output logic REF_BUFFER_ON,
    output logic REF_PIN_OD_BLOCK
);

    // ************************************************************
    // Address decode
    // ************************************************************

    // Register hit for one address and page, shared by read and write
    function automatic logic rtsc_hit(input logic [7:0] addr, input logic [7:0] page);
        rtsc_hit = (addr == RTSC_REF_CTL_ADDR) && (page == RTSC_REF_CTL_PAGE);
    endfunction : rtsc_hit

    logic wr_hit;       // Write to this register
    logic rd_hit;       // Read of this register

    assign wr_hit = SFR_WR && rtsc_hit(SFR_ADDR, SFR_PAGE);
    assign rd_hit = SFR_RD && rtsc_hit(SFR_ADDR, SFR_PAGE);

    // ************************************************************
    // Field storage
    // ************************************************************
    rtsc_reg_if regs ();

    assign regs.wr_en = wr_hit;
    assign regs.wr_data = SFR_WDATA;

    rtsc_field_reg u_field_reg
    (
        .CLK(CLK),
        .RESET(RESET),
        .regs(regs)
    );

    // Named views of the stored fields
    logic buf_en;       // reference_buffer_enable
    logic bias_en;      // bias_generator_enable
    logic temp_en;      // temp_sensor_enable
    logic src_sel;      // reference_source_select

    assign buf_en = regs.ctl[RTSC_BIT_BUF_EN];
    assign bias_en = regs.ctl[RTSC_BIT_BIAS_EN];
    assign temp_en = regs.ctl[RTSC_BIT_TEMP_EN];
    assign src_sel = regs.ctl[RTSC_BIT_SRC_SEL];

    // ************************************************************
    // Read path
    // ************************************************************
    logic [7:0] rd_word;        // Assembled register image
    logic [7:0] rdata_next;     // Next read data

    // Read-only bits come live from hardware, so writes never touch them
    assign rd_word = {RTSC_UNUSED_RD, ZERO_TC_BIAS_FORCE, REF_LEVEL_SELECT,
                      regs.ctl};

    // Unselected reads return zero so a wired-OR read bus stays clean
    assign rdata_next = rd_hit ? rd_word : 8'h00;

    // ************************************************************
    // Control decode
    // ************************************************************
    logic bias_next;        // Main bias demand
    logic ztc_next;         // Zero-TC bias demand
    logic sample_next;      // Sensor channel gives a usable sample
    logic od_block_next;    // Shared pin may not be open-drain

    // Any dependent peripheral or the manual bit turns the bias on
    assign bias_next = bias_en || ADC_ENABLE || temp_en || OSC_ENABLE;

    // Oscillator wants this bias; software may force it for suspend
    assign ztc_next = ZERO_TC_BIAS_FORCE || OSC_ENABLE;

    // A conversion on the sensor channel is meaningful only when powered
    assign sample_next = temp_en && (ADC_CHANNEL_SELECT == RTSC_CH_TEMP);

    // The supply reference with the ADC on needs the pin kept off open-drain
    assign od_block_next = (src_sel == RTSC_SRC_SUPPLY) && ADC_ENABLE;

    // ************************************************************
    // Output registers
    // ************************************************************

    // All outputs are flops; they follow the fields one cycle later
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            SFR_RDATA <= RTSC_REF_CTL_RESET;
            REF_SOURCE_SUPPLY <= RTSC_SRC_PIN;
            TEMP_SENSOR_POWER <= 1'b0;
            TEMP_SENSOR_OUT_EN <= 1'b0;
            TEMP_SAMPLE_VALID <= 1'b0;
            BIAS_GEN_ON <= 1'b0;
            ZERO_TC_BIAS_ON <= 1'b0;
            REF_BUFFER_ON <= 1'b0;
            REF_PIN_OD_BLOCK <= 1'b0;
        end
        else
        begin
            SFR_RDATA <= rdata_next;
            REF_SOURCE_SUPPLY <= src_sel;
            TEMP_SENSOR_POWER <= temp_en;
            TEMP_SENSOR_OUT_EN <= temp_en;
            TEMP_SAMPLE_VALID <= sample_next;
            BIAS_GEN_ON <= bias_next;
            ZERO_TC_BIAS_ON <= ztc_next;
            REF_BUFFER_ON <= buf_en;
            REF_PIN_OD_BLOCK <= od_block_next;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************

    // A write to the register shows on the source output two edges later
    chk_source_follows_write: assert property (
        @(posedge CLK) disable iff (RESET)
        (wr_hit ##1 !wr_hit) |-> ##1 (REF_SOURCE_SUPPLY == $past(SFR_WDATA[RTSC_BIT_SRC_SEL], 2)))
        else $error("reference source does not follow written bit");

    // Sensor power follows its enable field; output enable matches power
    chk_sensor_power_hiz: assert property (
        @(posedge CLK) disable iff (RESET)
        (TEMP_SENSOR_POWER == $past(temp_en)) && (TEMP_SENSOR_POWER == TEMP_SENSOR_OUT_EN))
        else $error("sensor power or output enable wrong");

    // No valid sample while the sensor is unpowered
    chk_sample_needs_power: assert property (
        @(posedge CLK) disable iff (RESET)
        TEMP_SAMPLE_VALID |-> TEMP_SENSOR_POWER)
        else $error("sample valid while sensor off");

    // ADC enable turns the bias on one edge later
    chk_bias_auto_adc: assert property (
        @(posedge CLK) disable iff (RESET)
        ADC_ENABLE |=> BIAS_GEN_ON)
        else $error("bias off while ADC enabled");

    // Writing the manual bit forces bias on two edges later
    chk_bias_manual_force: assert property (
        @(posedge CLK) disable iff (RESET)
        (wr_hit && SFR_WDATA[RTSC_BIT_BIAS_EN]) ##1 !wr_hit |-> ##1 BIAS_GEN_ON)
        else $error("bias not forced by manual bit");

    // Bias off only when no demand existed one cycle before
    chk_bias_off_cause: assert property (
        @(posedge CLK) disable iff (RESET)
        !BIAS_GEN_ON |-> !$past(ADC_ENABLE) && !$past(OSC_ENABLE) && !$past(bias_en)
            && !$past(temp_en))
        else $error("bias off despite demand");

    // Buffer output comes on one cycle after its enable field rises
    chk_buffer_tracks: assert property (
        @(posedge CLK) disable iff (RESET)
        $rose(buf_en) |=> REF_BUFFER_ON)
        else $error("reference buffer not on after enable");

    // Read answer shows level and force bits and zeros in 7:6
    chk_read_image: assert property (
        @(posedge CLK) disable iff (RESET)
        rd_hit |=> (SFR_RDATA[7:6] == RTSC_UNUSED_RD)
            && (SFR_RDATA[RTSC_BIT_LEVEL] == $past(REF_LEVEL_SELECT))
            && (SFR_RDATA[RTSC_BIT_ZTC] == $past(ZERO_TC_BIAS_FORCE)))
        else $error("read image wrong in read-only bits");

    // Writable fields take the written value on the next edge
    chk_write_same_cycle: assert property (
        @(posedge CLK) disable iff (RESET)
        wr_hit |=> regs.ctl == $past(SFR_WDATA[RTSC_CTL_W-1:0]))
        else $error("fields not updated by write");

    // Writes elsewhere leave fields alone
    chk_decode_page: assert property (
        @(posedge CLK) disable iff (RESET)
        !wr_hit |=> $stable(regs.ctl))
        else $error("fields changed without a hit");

    // Open-drain block raised only by supply reference with ADC on
    chk_od_block_cause: assert property (
        @(posedge CLK) disable iff (RESET)
        REF_PIN_OD_BLOCK |-> $past(src_sel) && $past(ADC_ENABLE))
        else $error("open-drain block without cause");

    // After reset every writable field starts at zero and bias is off
    chk_reset_zero: assert property (
        @(posedge CLK)
        $fell(RESET) |-> (regs.ctl == RTSC_CTL_RESET) && !BIAS_GEN_ON)
        else $error("fields not zero after reset");

endmodule : rtsc_top

// ==== tb/rtsc_testbench.sv ====
// Self-checking bench for the reference and temperature sensor control block.
// Assumes the design files under core/ are compiled first; no partner model.
`timescale 1ns/1ps
module testbench
    import rtsc_pkg::*;
;
    // ************************************************************
    // Signals
    // ************************************************************
    logic clk;                  // 100 MHz system clock
    logic reset;                // Synchronous, active high
    logic [7:0] addr;           // Register address
    logic [7:0] page;           // Register page
    logic [7:0] wdata;          // Write data
    logic wr;                   // Write strobe
    logic rd;                   // Read strobe
    logic [7:0] rdata;          // Read data
    logic adc_en;               // Neighbour status inputs
    logic osc_en;
    logic [5:0] chan;
    logic lvl;
    logic ztc;
    logic [7:0] outs;           // All analog controls, packed
    int mismatches;             // Failed comparisons
    int cmp_count;              // All comparisons

    // Device under test; outputs packed MSB first
    rtsc_top dut_u
    (
        .CLK(clk),
        .RESET(reset),
        .SFR_ADDR(addr),
        .SFR_PAGE(page),
        .SFR_WR(wr),
        .SFR_RD(rd),
        .SFR_WDATA(wdata),
        .SFR_RDATA(rdata),
        .ADC_ENABLE(adc_en),
        .OSC_ENABLE(osc_en),
        .ADC_CHANNEL_SELECT(chan),
        .REF_LEVEL_SELECT(lvl),
        .ZERO_TC_BIAS_FORCE(ztc),
        .REF_SOURCE_SUPPLY(outs[7]),
        .TEMP_SENSOR_POWER(outs[6]),
        .TEMP_SENSOR_OUT_EN(outs[5]),
        .TEMP_SAMPLE_VALID(outs[4]),
        .BIAS_GEN_ON(outs[3]),
        .ZERO_TC_BIAS_ON(outs[2]),
        .REF_BUFFER_ON(outs[1]),
        .REF_PIN_OD_BLOCK(outs[0])
    );

    // Free-running clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    // Step to just after the next rising edge, so drives never race it
    task tick;
        @(posedge clk);
        #1;
    endtask : tick

    task chk_reg(input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] t=%0t reg exp=%h got=%h", $time, e, g);
        end
    endtask : chk_reg

    task chk_out(input logic [7:0] e);
        cmp_count++;
        if (outs !== e)
        begin
            mismatches++;
            $display("[ERR] t=%0t out exp=%h got=%h", $time, e, outs);
        end
    endtask : chk_out

    // One-cycle write strobe; caller lets an edge pass before the next
    task bus_wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
        addr = a;
        page = p;
        wdata = d;
        wr = 1'b1;
        tick;
        wr = 1'b0;
    endtask : bus_wr

    // Read data is registered, so it is valid right after the taking edge
    task bus_rd(input logic [7:0] a, input logic [7:0] p, output logic [7:0] d);
        addr = a;
        page = p;
        rd = 1'b1;
        tick;
        rd = 1'b0;
        d = rdata;
    endtask : bus_rd

    // Expected controls from writable fields and current status inputs
    function automatic logic [7:0] exp_outs(input logic [3:0] n);
        return {n[3], n[2], n[2], n[2] && (chan == RTSC_CH_TEMP),
            n[1] | adc_en | n[2] | osc_en, ztc | osc_en, n[0], n[3] & adc_en};
    endfunction : exp_outs

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Reset image, and read data standing one cycle only
    task t_reset;
        logic [7:0] d;
        chk_out(8'h00);
        bus_rd(RTSC_REF_CTL_ADDR, RTSC_REF_CTL_PAGE, d);
        chk_reg(RTSC_REF_CTL_RESET, d);
        tick;
        chk_reg(8'h00, rdata);
        $display("test reset done");
    endtask : t_reset

    // Every field value against every ADC and oscillator enable mix; top bits written as ones
    task t_fields;
        logic [7:0] d;
        logic [5:0] i;
        for (int k = 0; k < 64; k++)
        begin
            i = k[5:0];
            adc_en = i[4];
            osc_en = i[5];
            chan = (i[5] ^ i[0]) ? RTSC_CH_TEMP : 6'h31;
            lvl = i[1] ^ i[5];
            ztc = i[2] ^ i[4];
            bus_wr(RTSC_REF_CTL_ADDR, RTSC_REF_CTL_PAGE, {4'hf, i[3:0]});
            // Let the outputs settle after the write lands
            tick;
            tick;
            chk_out(exp_outs(i[3:0]));
            bus_rd(RTSC_REF_CTL_ADDR, RTSC_REF_CTL_PAGE, d);
            chk_reg({RTSC_UNUSED_RD, ztc, lvl, i[3:0]}, d);
        end
        $display("test fields done");
    endtask : t_fields

    // Status inputs reach the bias controls one cycle later
    task t_status;
        adc_en = 1'b0;
        osc_en = 1'b0;
        ztc = 1'b0;
        bus_wr(RTSC_REF_CTL_ADDR, RTSC_REF_CTL_PAGE, 8'h00);
        tick;
        tick;
        adc_en = 1'b1;
        tick;
        chk_out(exp_outs(4'h0));
        adc_en = 1'b0;
        osc_en = 1'b1;
        tick;
        chk_out(exp_outs(4'h0));
        osc_en = 1'b0;
        ztc = 1'b1;
        tick;
        chk_out(exp_outs(4'h0));
        // Sensor enabled first, then its channel chosen
        bus_wr(RTSC_REF_CTL_ADDR, RTSC_REF_CTL_PAGE, 8'h04);
        tick;
        chan = RTSC_CH_TEMP;
        tick;
        chk_out(exp_outs(4'h4));
        $display("test status done");
    endtask : t_status

    // Wrong address or page: writes dropped, reads give zero
    task t_unmapped;
        logic [7:0] d;
        bus_wr(RTSC_REF_CTL_ADDR, RTSC_REF_CTL_PAGE, 8'h0a);
        tick;
        bus_wr(8'hd2, RTSC_REF_CTL_PAGE, 8'h05);
        tick;
        bus_wr(RTSC_REF_CTL_ADDR, 8'h01, 8'h05);
        bus_rd(8'hd0, RTSC_REF_CTL_PAGE, d);
        chk_reg(8'h00, d);
        tick;
        bus_rd(RTSC_REF_CTL_ADDR, 8'h01, d);
        chk_reg(8'h00, d);
        tick;
        bus_rd(RTSC_REF_CTL_ADDR, RTSC_REF_CTL_PAGE, d);
        chk_reg({RTSC_UNUSED_RD, ztc, lvl, 4'ha}, d);
        // Read data stands one cycle, then falls back to zero
        tick;
        chk_reg(8'h00, rdata);
        $display("test unmapped done");
    endtask : t_unmapped

    // Write and read in one cycle: read sees the old fields
    task t_collide;
        logic [7:0] d;
        addr = RTSC_REF_CTL_ADDR;
        page = RTSC_REF_CTL_PAGE;
        wdata = 8'h03;
        wr = 1'b1;
        rd = 1'b1;
        tick;
        wr = 1'b0;
        rd = 1'b0;
        chk_reg({RTSC_UNUSED_RD, ztc, lvl, 4'ha}, rdata);
        tick;
        bus_rd(RTSC_REF_CTL_ADDR, RTSC_REF_CTL_PAGE, d);
        chk_reg({RTSC_UNUSED_RD, ztc, lvl, 4'h3}, d);
        $display("test collide done");
    endtask : t_collide

    // ************************************************************
    // Run control
    // ************************************************************
    task final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    // Main sequence; every input has a value at time zero
    initial
    begin
        mismatches = 0;
        cmp_count = 0;
        reset = 1'b1;
        addr = RTSC_REF_CTL_ADDR;
        page = RTSC_REF_CTL_PAGE;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        adc_en = 1'b0;
        osc_en = 1'b0;
        chan = 6'h00;
        lvl = 1'b0;
        ztc = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        reset = 1'b0;
        t_reset;
        t_fields;
        t_status;
        t_unmapped;
        t_collide;
        final_report;
    end

    // Watchdog: tests need well under 1000 cycles, so 5000 means a hang
    initial
    begin
        #50000;
        mismatches++;
        $display("watchdog expired");
        final_report;
    end

endmodule : testbench
